// ### hdl/fbbm_consts.svh
`ifndef FBBM_CONSTS_SVH
`define FBBM_CONSTS_SVH
// Overview of operation
// - Sync pulse arrives on the fourth digital input.
// - Enabled monitor idles until a start pulse.
// - Relay option drives relay two on break.
// - Bag count marks the end of cycle.
// - Interval setting spaces consecutive bags.
// - Delay precedes evaluation of the first bag.
// - Damped concentration at limit flags a break.
// - Monitor concentration has its own damping.
// - Cycle count clears at every restart.
// - Current bag index is readable.
// - Defective bags read as semicolon separated numbers.
// - Start pulse clears the defective bag list.
// - Counter attributes each peak to its bag.

`define FBBM_OFS_CTRL      6'h00
`define FBBM_OFS_BAGS      6'h04
`define FBBM_OFS_INTERVAL  6'h08
`define FBBM_OFS_DELAY     6'h0C
`define FBBM_OFS_LIMIT     6'h10
`define FBBM_OFS_DAMP      6'h14
`define FBBM_OFS_STATUS    6'h18
`define FBBM_OFS_CYCLES    6'h1C
`define FBBM_OFS_BAGIDX    6'h20
`define FBBM_OFS_CONC      6'h24
`define FBBM_OFS_LISTCHR   6'h28
`define FBBM_OFS_LISTRST   6'h2C
`define FBBM_OFS_IRQST     6'h30
`define FBBM_OFS_IRQMASK   6'h34

`define FBBM_CTRL_EN       0
`define FBBM_CTRL_RELAY    1
`define FBBM_ST_WAIT       0
`define FBBM_ST_ACTIVE     1
`define FBBM_ST_BREAK      2
`define FBBM_IRQ_START     0
`define FBBM_IRQ_END       1
`define FBBM_IRQ_BREAK     2

`define FBBM_RST_BAGS      8'h64
`define FBBM_RST_INTERVAL  16'h07D0
`define FBBM_RST_DELAY     16'h0000
`define FBBM_RST_LIMIT     16'h01F4
`define FBBM_RST_DAMP      4'h6

`define FBBM_LIST_DEPTH    32
`define FBBM_MS_NS         1000000
`define FBBM_CLK_NS        8
`endif

// ### hdl/fbbm_damper.sv
`timescale 1ns/1ps
`default_nettype none
module fbbm_damper (
    input  wire logic        mclk,     // System clock.
    input  wire logic        rst_n,    // Asynchronous reset, active low.
    input  wire logic        tick,     // One millisecond step.
    input  wire logic [15:0] concIn,   // Raw concentration.
    input  wire logic [3:0]  shift,    // Damping response time code.
    output logic      [15:0] damped    // Damped monitor concentration.
);
    // Eight fraction bits keep long time constants from stalling on rounding.
    logic [23:0] acc;
    logic [23:0] next_acc;
    logic signed [24:0] diff;

    always_comb begin
        diff     = $signed({1'b0, concIn, 8'h00}) - $signed({1'b0, acc});
        next_acc = acc;
        if (tick) begin
            next_acc = 24'(acc + 24'(diff >>> shift));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 24'h000000;
        end else begin
            acc <= next_acc;
        end
    end

    assign damped = acc[23:8];
endmodule
`default_nettype wire

// ### hdl/fbbm_defect_list.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbbm_consts.svh"
module fbbm_defect_list (
    input  wire logic       mclk,      // System clock.
    input  wire logic       rst_n,     // Asynchronous reset, active low.
    input  wire logic       clear,     // Empty the list.
    input  wire logic       add,       // Append a bag number.
    input  wire logic [7:0] addNum,    // Bag number to append.
    input  wire logic       rdRestart, // Rewind the text reader.
    input  wire logic       rdNext,    // Advance one character.
    output logic      [7:0] listChar,  // Current ASCII character, zero at end.
    output logic      [5:0] count      // Entries held.
);
    logic [7:0] mem [`FBBM_LIST_DEPTH];
    logic [5:0] rdEntry;
    logic [1:0] rdDigit;
    logic [5:0] next_count;
    logic [5:0] next_rdEntry;
    logic [1:0] next_rdDigit;
    logic [7:0] num;

    function automatic logic [1:0] firstDigit(input logic [7:0] n);
        firstDigit = (n >= 8'h64) ? 2'h0 : ((n >= 8'h0A) ? 2'h1 : 2'h2);
    endfunction

    always_comb begin
        num          = mem[5'(rdEntry)];
        next_count   = count;
        next_rdEntry = rdEntry;
        next_rdDigit = rdDigit;
        // Entries beyond the depth are dropped; the break flag still records them.
        if (clear) begin
            next_count = 6'h00;
        end else if (add && count < 6'(`FBBM_LIST_DEPTH)) begin
            next_count = 6'(count + 6'h01);
        end
        if (rdRestart || clear) begin
            next_rdEntry = 6'h00;
            next_rdDigit = firstDigit(mem[0]);
        end else if (rdNext && rdEntry < count) begin
            if (rdDigit == 2'h3 || (rdDigit == 2'h2 && 6'(rdEntry + 6'h01) == count)) begin
                next_rdEntry = 6'(rdEntry + 6'h01);
                next_rdDigit = firstDigit(mem[5'(rdEntry + 6'h01)]);
            end else begin
                next_rdDigit = 2'(rdDigit + 2'h1);
            end
        end
        // A reader parked at the end would otherwise keep the digit count of a stale entry.
        if (add && !clear && count < 6'(`FBBM_LIST_DEPTH) && next_rdEntry == count) begin
            next_rdDigit = firstDigit(addNum);
        end
        case (rdDigit)
            2'h0:    listChar = 8'h30 + 8'(num / 8'h64);
            2'h1:    listChar = 8'h30 + 8'((num / 8'h0A) % 8'h0A);
            2'h2:    listChar = 8'h30 + 8'(num % 8'h0A);
            default: listChar = 8'h3B;
        endcase
        if (rdEntry >= count) begin
            listChar = 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 6'h00;
            rdEntry <= 6'h00;
            rdDigit <= 2'h0;
        end else begin
            count   <= next_count;
            rdEntry <= next_rdEntry;
            rdDigit <= next_rdDigit;
        end
    end

    always_ff @(posedge mclk) begin
        if (add && !clear && count < 6'(`FBBM_LIST_DEPTH)) begin
            mem[5'(count)] <= addNum;
        end
    end
endmodule
`default_nettype wire

// ### hdl/fbbm_pkg.sv
`default_nettype none
package fbbm_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_DELAY, ST_EVAL} fbbm_state_t;

    typedef struct packed {
        logic        enable;
        logic        relayOpt;
        logic [7:0]  bagCount;
        logic [15:0] interval;
        logic [15:0] delay;
        logic [15:0] limit;
        logic [3:0]  dampShift;
    } fbbm_cfg_t;
endpackage
`default_nettype wire

// ### hdl/fbbm_top.sv
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fbbm_consts.svh"
module fbbm_top #(
    parameter int unsigned MS_CYCLES = `FBBM_MS_NS / `FBBM_CLK_NS
) (
    input  wire logic        mclk,          // System clock, 125 MHz.
    input  wire logic        rst_n,         // Asynchronous reset, active low.
    input  wire logic [5:0]  avAddress,     // Avalon byte address.
    input  wire logic        avRead,        // Avalon read request.
    input  wire logic        avWrite,       // Avalon write request.
    input  wire logic [31:0] avWritedata,   // Avalon write data.
    input  wire logic [3:0]  avByteenable,  // Avalon byte lanes.
    output logic      [31:0] avReaddata,    // Avalon read data.
    output logic             avWaitrequest, // Avalon wait request.
    input  wire logic        syncTrigger,   // Plant sync pulse, fourth digital input.
    input  wire logic [15:0] concIn,        // Concentration measurement.
    output logic             relay2,        // Second relay, filter break.
    output logic             irq            // Interrupt, active high level.
);
    ////////////////////////////////////////////////////////////////////////////
    fbbm_pkg::fbbm_cfg_t   cfg;
    fbbm_pkg::fbbm_cfg_t   next_cfg;
    fbbm_pkg::fbbm_state_t state;
    fbbm_pkg::fbbm_state_t next_state;
    logic [2:0]  irqMask;
    logic [2:0]  next_irqMask;
    logic        next_avWaitrequest;
    logic [31:0] next_avReaddata;
    logic [16:0] msCnt;
    logic [16:0] next_msCnt;
    logic [15:0] timeCnt;
    logic [15:0] next_timeCnt;
    logic [7:0]  bagIndex;
    logic [7:0]  next_bagIndex;
    logic        bagHit;
    logic        next_bagHit;
    logic        breakFlag;
    logic        next_breakFlag;
    logic [31:0] cycles;
    logic [31:0] next_cycles;
    logic [2:0]  irqStatus;
    logic [2:0]  next_irqStatus;
    logic        next_relay2;
    logic        next_irq;
    logic        syncPrev;
    logic        syncRise;
    logic        tick;
    logic        wrDone;
    logic        rdDone;
    logic        startCycle;
    logic        listAdd;
    logic [15:0] damped;
    logic [7:0]  listChar;
    logic [5:0]  listCount;
    logic [7:0]  bagLimit;
    logic [15:0] stepLimit;

    function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                old[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        beMerge = old;
    endfunction

    assign wrDone     = avWrite && !avWaitrequest;
    assign rdDone     = avRead && !avWaitrequest;
    assign tick       = (msCnt == 17'(MS_CYCLES - 1));
    assign syncRise   = syncTrigger && !syncPrev;
    assign startCycle = (state == fbbm_pkg::ST_WAIT) && syncRise;
    // A zero bag count or interval would hang the cycle, so both count as one.
    assign bagLimit   = (cfg.bagCount == 8'h00) ? 8'h01 : cfg.bagCount;
    assign stepLimit  = (cfg.interval == 16'h0000) ? 16'h0001 : cfg.interval;
    assign listAdd    = (state == fbbm_pkg::ST_EVAL) && !bagHit && (damped >= cfg.limit);

    ////////////////////////////////////////////////////////////////////////////
    fbbm_damper u_damper (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tick   (tick),
        .concIn (concIn),
        .shift  (cfg.dampShift),
        .damped (damped)
    );

    fbbm_defect_list u_list (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .clear     (startCycle),
        .add       (listAdd),
        .addNum    (bagIndex),
        .rdRestart (wrDone && avAddress == `FBBM_OFS_LISTRST),
        .rdNext    (rdDone && avAddress == `FBBM_OFS_LISTCHR),
        .listChar  (listChar),
        .count     (listCount)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The bus answers one cycle after a request appears; a held request then completes.
    always_comb begin
        next_cfg           = cfg;
        next_irqMask       = irqMask;
        next_avWaitrequest = !((avRead || avWrite) && avWaitrequest);
        next_avReaddata    = avReaddata;
        if (wrDone) begin
            case (avAddress)
                `FBBM_OFS_CTRL: begin
                    if (avByteenable[0]) begin
                        next_cfg.enable   = avWritedata[`FBBM_CTRL_EN];
                        next_cfg.relayOpt = avWritedata[`FBBM_CTRL_RELAY];
                    end
                end
                `FBBM_OFS_BAGS:     next_cfg.bagCount  = 8'(beMerge({24'h000000, cfg.bagCount}, avWritedata, avByteenable));
                `FBBM_OFS_INTERVAL: next_cfg.interval  = 16'(beMerge({16'h0000, cfg.interval}, avWritedata, avByteenable));
                `FBBM_OFS_DELAY:    next_cfg.delay     = 16'(beMerge({16'h0000, cfg.delay}, avWritedata, avByteenable));
                `FBBM_OFS_LIMIT:    next_cfg.limit     = 16'(beMerge({16'h0000, cfg.limit}, avWritedata, avByteenable));
                `FBBM_OFS_DAMP: begin
                    if (avByteenable[0]) begin
                        next_cfg.dampShift = avWritedata[3:0];
                    end
                end
                `FBBM_OFS_IRQMASK: begin
                    if (avByteenable[0]) begin
                        next_irqMask = avWritedata[2:0];
                    end
                end
                default: ;
            endcase
        end
        if ((avRead || avWrite) && avWaitrequest) begin
            case (avAddress)
                `FBBM_OFS_CTRL:     next_avReaddata = {30'h00000000, cfg.relayOpt, cfg.enable};
                `FBBM_OFS_BAGS:     next_avReaddata = {24'h000000, cfg.bagCount};
                `FBBM_OFS_INTERVAL: next_avReaddata = {16'h0000, cfg.interval};
                `FBBM_OFS_DELAY:    next_avReaddata = {16'h0000, cfg.delay};
                `FBBM_OFS_LIMIT:    next_avReaddata = {16'h0000, cfg.limit};
                `FBBM_OFS_DAMP:     next_avReaddata = {28'h0000000, cfg.dampShift};
                `FBBM_OFS_STATUS: begin
                    next_avReaddata = {29'h00000000, breakFlag,
                                       (state == fbbm_pkg::ST_DELAY || state == fbbm_pkg::ST_EVAL),
                                       (state == fbbm_pkg::ST_WAIT)};
                end
                `FBBM_OFS_CYCLES:   next_avReaddata = cycles;
                `FBBM_OFS_BAGIDX:   next_avReaddata = {24'h000000, bagIndex};
                `FBBM_OFS_CONC:     next_avReaddata = {16'h0000, damped};
                `FBBM_OFS_LISTCHR:  next_avReaddata = {24'h000000, listChar};
                `FBBM_OFS_IRQST:    next_avReaddata = {29'h00000000, irqStatus};
                `FBBM_OFS_IRQMASK:  next_avReaddata = {29'h00000000, irqMask};
                default:            next_avReaddata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg           <= '{enable: 1'b0, relayOpt: 1'b0, bagCount: `FBBM_RST_BAGS,
                               interval: `FBBM_RST_INTERVAL, delay: `FBBM_RST_DELAY,
                               limit: `FBBM_RST_LIMIT, dampShift: `FBBM_RST_DAMP};
            irqMask       <= 3'h0;
            avWaitrequest <= 1'b1;
            avReaddata    <= 32'h00000000;
        end else begin
            cfg           <= next_cfg;
            irqMask       <= next_irqMask;
            avWaitrequest <= next_avWaitrequest;
            avReaddata    <= next_avReaddata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state     = state;
        next_msCnt     = tick ? 17'h00000 : 17'(msCnt + 17'h00001);
        next_timeCnt   = timeCnt;
        next_bagIndex  = bagIndex;
        next_bagHit    = bagHit;
        next_breakFlag = breakFlag;
        next_cycles    = cycles;
        next_irqStatus = irqStatus;
        if (wrDone && avAddress == `FBBM_OFS_IRQST && avByteenable[0]) begin
            next_irqStatus = irqStatus & ~avWritedata[2:0];
        end
        case (state)
            fbbm_pkg::ST_OFF: begin
                if (cfg.enable) begin
                    next_state = fbbm_pkg::ST_WAIT;
                end
            end
            fbbm_pkg::ST_WAIT: begin
                if (startCycle) begin
                    next_state     = fbbm_pkg::ST_DELAY;
                    next_msCnt     = 17'h00000;
                    next_timeCnt   = 16'h0000;
                    next_breakFlag = 1'b0;
                    next_irqStatus[`FBBM_IRQ_START] = 1'b1;
                end
            end
            fbbm_pkg::ST_DELAY: begin
                if (timeCnt >= cfg.delay) begin
                    next_state    = fbbm_pkg::ST_EVAL;
                    next_bagIndex = 8'h01;
                    next_bagHit   = 1'b0;
                    next_timeCnt  = 16'h0000;
                end else if (tick) begin
                    next_timeCnt = 16'(timeCnt + 16'h0001);
                end
            end
            fbbm_pkg::ST_EVAL: begin
                // Only the first crossing per bag is logged, so a long peak is one entry.
                if (listAdd) begin
                    next_bagHit    = 1'b1;
                    next_breakFlag = 1'b1;
                    next_irqStatus[`FBBM_IRQ_BREAK] = 1'b1;
                end
                if (timeCnt >= stepLimit) begin
                    next_timeCnt = 16'h0000;
                    next_bagHit  = 1'b0;
                    if (bagIndex >= bagLimit) begin
                        next_state  = fbbm_pkg::ST_WAIT;
                        next_cycles = 32'(cycles + 32'h00000001);
                        next_irqStatus[`FBBM_IRQ_END] = 1'b1;
                    end else begin
                        next_bagIndex = 8'(bagIndex + 8'h01);
                    end
                end else if (tick) begin
                    next_timeCnt = 16'(timeCnt + 16'h0001);
                end
            end
            default: next_state = fbbm_pkg::ST_OFF;
        endcase
        if (!cfg.enable) begin
            next_state = fbbm_pkg::ST_OFF;
        end
        next_relay2 = next_breakFlag && cfg.relayOpt;
        next_irq    = |(next_irqStatus & irqMask);
    end

    // Reset is the device restart; the cycle count starts from zero there.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= fbbm_pkg::ST_OFF;
            msCnt     <= 17'h00000;
            timeCnt   <= 16'h0000;
            bagIndex  <= 8'h00;
            bagHit    <= 1'b0;
            breakFlag <= 1'b0;
            cycles    <= 32'h00000000;
            irqStatus <= 3'h0;
            relay2    <= 1'b0;
            irq       <= 1'b0;
            syncPrev  <= 1'b0;
        end else begin
            state     <= next_state;
            msCnt     <= next_msCnt;
            timeCnt   <= next_timeCnt;
            bagIndex  <= next_bagIndex;
            bagHit    <= next_bagHit;
            breakFlag <= next_breakFlag;
            cycles    <= next_cycles;
            irqStatus <= next_irqStatus;
            relay2    <= next_relay2;
            irq       <= next_irq;
            syncPrev  <= syncTrigger;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence sDelayToEval;
        state == fbbm_pkg::ST_DELAY ##1 state == fbbm_pkg::ST_EVAL;
    endsequence
    sequence sEvalToWait;
        state == fbbm_pkg::ST_EVAL ##1 state == fbbm_pkg::ST_WAIT;
    endsequence

    AST_SYNC_ONLY: assert property ((state == fbbm_pkg::ST_WAIT && !syncRise) |=> state != fbbm_pkg::ST_DELAY)
        else $error("Cycle started without a sync edge.");
    AST_IDLE_WAIT: assert property ((state == fbbm_pkg::ST_OFF && cfg.enable) |=> state == fbbm_pkg::ST_WAIT)
        else $error("Enabled monitor did not enter waiting state.");
    AST_RELAY_ON: assert property ((breakFlag && cfg.relayOpt && !startCycle) |=> relay2)
        else $error("Relay not driven on filter break.");
    AST_RELAY_OFF: assert property (!$past(cfg.relayOpt) |-> !relay2)
        else $error("Relay driven without relay option.");
    AST_CYCLE_END: assert property (sEvalToWait |-> ($past(bagIndex) >= $past(bagLimit)) && cycles == $past(cycles) + 32'h00000001)
        else $error("Cycle ended at wrong bag or count not incremented.");
    AST_BAG_STEP: assert property ((state == fbbm_pkg::ST_EVAL && $past(state) == fbbm_pkg::ST_EVAL && $changed(bagIndex))
                                   |-> bagIndex == $past(bagIndex) + 8'h01 && $past(timeCnt) >= $past(stepLimit))
        else $error("Bag index stepped wrongly.");
    AST_FIRST_BAG: assert property (sDelayToEval |-> bagIndex == 8'h01 && $past(timeCnt) >= $past(cfg.delay))
        else $error("First bag not selected after delay.");
    AST_BREAK: assert property (listAdd |=> breakFlag && (bagHit || timeCnt == 16'h0000))
        else $error("Limit reached but no break flagged.");
    AST_COUNT_STEP: assert property ($changed(cycles) |-> cycles == $past(cycles) + 32'h00000001)
        else $error("Cycle count changed by other than one.");
    AST_LIST_CLEAR: assert property (startCycle |=> listCount == 6'h00 && !breakFlag)
        else $error("Start pulse did not clear defect list.");
    AST_ONE_ENTRY: assert property ((state == fbbm_pkg::ST_EVAL && bagHit && $stable(bagIndex)) |-> !listAdd)
        else $error("Bag logged twice in one interval.");
    AST_IRQ_LEVEL: assert property (irq == |(irqStatus & $past(irqMask)))
        else $error("Interrupt not raised for unmasked status.");
    AST_BUS_ACK: assert property (((avRead || avWrite) && avWaitrequest) |=> !avWaitrequest)
        else $error("Bus request not answered within one cycle.");
endmodule
`default_nettype wire

// ### test/fbbm_plant_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fbbm_plant_sync #(
    parameter int WIDTH = 1000          // Pulse length in clocks.
) (
    input  wire logic mclk,             // System clock.
    input  wire logic fire,             // Request one sync pulse.
    output logic      syncTrigger       // Debounced sync level.
);
    int left = 0;
    initial syncTrigger = 1'b0;
    // The level is clean and held long, so the device sees exactly one rising edge.
    always @(posedge mclk) begin
        if (fire && left == 0) begin
            syncTrigger <= 1'b1;
            left <= WIDTH;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            syncTrigger <= 1'b0;
            left <= 0;
        end
    end
endmodule
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbbm_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
module testbench;
    logic        mclk = 1'b0, rst_n = 1'b0, avRead = 1'b0, avWrite = 1'b0, fire = 1'b0;
    logic [5:0]  avAddress = 6'h00;
    logic [31:0] avWritedata = 32'h0, avReaddata, q;
    logic [15:0] concIn = 16'h0000;
    logic        avWaitrequest, syncTrigger, relay2, irq;
    int          num_errors = 0, checks = 0, bag, defects;
    byte         exp[$];
    always #4 mclk = ~mclk;
    fbbm_top #(.MS_CYCLES(10)) u_dut (.mclk(mclk), .rst_n(rst_n), .avAddress(avAddress), .avRead(avRead),
        .avWrite(avWrite), .avWritedata(avWritedata), .avByteenable(4'hF), .avReaddata(avReaddata),
        .avWaitrequest(avWaitrequest), .syncTrigger(syncTrigger), .concIn(concIn), .relay2(relay2), .irq(irq));
    fbbm_plant_sync #(.WIDTH(1000)) u_plant (.mclk(mclk), .fire(fire), .syncTrigger(syncTrigger));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One Avalon transfer; a wait longer than one cycle is counted as a mismatch.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avAddress <= a;
        avWrite <= w;
        avRead <= ~w;
        avWritedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avWaitrequest !== 1'b0);
        q = avReaddata;
        avRead <= 1'b0;
        avWrite <= 1'b0;
        `CHK(n, 2)
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(85));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        concIn <= 16'($urandom_range(0, 255));
        rd(`FBBM_OFS_BAGS, 32'h00000064);
        rd(`FBBM_OFS_CYCLES, 32'h00000000);
        rd(6'h3C, 32'h00000000);
        bus(1'b1, `FBBM_OFS_BAGS, 32'h00000004);
        bus(1'b1, `FBBM_OFS_INTERVAL, 32'h000001F4);
        bus(1'b1, `FBBM_OFS_DELAY, 32'h00000001);
        bus(1'b1, `FBBM_OFS_LIMIT, 32'h00000100);
        bus(1'b1, `FBBM_OFS_DAMP, 32'h00000000);
        bus(1'b1, `FBBM_OFS_IRQMASK, 32'h00000007);
        bus(1'b1, `FBBM_OFS_CTRL, 32'h00000003);
        rd(`FBBM_OFS_STATUS, 32'h00000001);
        for (int c = 1; c <= 2; c++) begin
            bus(1'b1, `FBBM_OFS_CTRL, {30'h0, c == 1, 1'b1});
            defects = $urandom_range(0, 15);
            exp.delete();
            for (int b = 1; b <= 4; b++)
                if (defects[b-1]) begin
                    if (exp.size() > 0) exp.push_back(8'h3B);
                    exp.push_back(8'(8'h30 + b));
                end
            fire <= 1'b1;
            @(posedge mclk);
            fire <= 1'b0;
            bag = 0;
            while (bag < 4) begin
                bus(1'b0, `FBBM_OFS_BAGIDX, 32'h0);
                // The index of the previous cycle stands until the delay ends.
                if (q != bag && (bag != 0 || q == 32'h1)) begin
                    `CHK(q, 32'(bag + 1))
                    bag++;
                    if (bag == 1) rd(`FBBM_OFS_STATUS, 32'h00000002);
                    // A short peak keeps the damped value inside the current bag's slot.
                    if (defects[bag-1]) begin
                        concIn <= 16'h0200;
                        repeat (10) @(posedge mclk);
                        concIn <= 16'($urandom_range(0, 255));
                    end
                end
            end
            repeat (5010) @(posedge mclk);
            rd(`FBBM_OFS_STATUS, {29'h0, defects != 0, 2'b01});
            rd(`FBBM_OFS_CYCLES, 32'(c));
            rd(`FBBM_OFS_CONC, {16'h0, concIn});
            `CHK(relay2, defects != 0 && c == 1)
            `CHK(irq, 1'b1)
            rd(`FBBM_OFS_IRQST, (defects != 0) ? 32'h7 : 32'h3);
            foreach (exp[i]) rd(`FBBM_OFS_LISTCHR, {24'h0, exp[i]});
            rd(`FBBM_OFS_LISTCHR, 32'h00000000);
            if (exp.size() > 0) begin
                bus(1'b1, `FBBM_OFS_LISTRST, 32'h00000000);
                rd(`FBBM_OFS_LISTCHR, {24'h0, exp[0]});
            end
            bus(1'b1, `FBBM_OFS_IRQST, 32'h00000007);
            repeat (3) @(posedge mclk);
            `CHK(irq, 1'b0)
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
